//--- logic/serial_lane_crossbar_upper.sv
`timescale 1ns/1ns
module serial_lane_crossbar_upper (
    input  wire logic             core_clk,
    input  wire logic             nrst,
    input  wire logic [11:0]      regAddr,
    input  wire logic             regWrEn,
    input  wire logic [7:0]       regWrData,
    input  wire logic             regRdEn,
    output logic      [7:0]       regRdData,
    output logic                  regRdValid,
    input  wire logic [7:0][7:0]  phyData,
    input  wire logic [7:0]       phyValid,
    output logic      [7:0]       phyReady,
    input  wire logic             linkReady,
    output logic      [3:0][7:0]  logicalData,
    output logic      [3:0]       logicalValid
);
    // Reset release pipeline
    logic [1:0] rstPipe;
    logic       rstn;
    // Registered and next state
    lane_xbar_pkg::state_t st_reg;
    lane_xbar_pkg::state_t st_next;
    // Decoded per-input flags and heads
    logic [7:0]      fullBits;
    logic [7:0]      emptyBits;
    logic [7:0][7:0] headData;
    // Select per logical lane, index 0 is lane 4
    logic [3:0][2:0] sel;
    logic [3:0][7:0] selHead;
    logic [3:0]      selValid;

    // Two-flop release of the async reset
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            rstPipe <= 2'h0;
        end else begin
            rstPipe <= {rstPipe[0], 1'b1};
        end
    end
    assign rstn = rstPipe[1];

    // Per-input status and head of buffer
    genvar n;
    generate
        for (n = 0; n < lane_xbar_pkg::PHY_LANES; n++) begin : g_phy
            assign fullBits[n]  = st_reg.cnt[n] == lane_xbar_pkg::CNT_FULL;
            assign emptyBits[n] = st_reg.cnt[n] == 2'h0;
            assign headData[n]  = st_reg.mem[n][st_reg.rp[n]];
        end
    endgenerate

    // Select fields out of the two route registers
    assign sel[0] = st_reg.route45[lane_xbar_pkg::SEL_LO_LSB +: 3];
    assign sel[1] = st_reg.route45[lane_xbar_pkg::SEL_HI_LSB +: 3];
    assign sel[2] = st_reg.route67[lane_xbar_pkg::SEL_LO_LSB +: 3];
    assign sel[3] = st_reg.route67[lane_xbar_pkg::SEL_HI_LSB +: 3];

    // Crossbar: each logical lane picks any input, sharing allowed
    genvar k;
    generate
        for (k = 0; k < lane_xbar_pkg::LOG_LANES; k++) begin : g_log
            assign selHead[k]  = headData[sel[k]];
            assign selValid[k] = !emptyBits[sel[k]];
        end
    endgenerate

    // Next-state logic for buffers, crossbar and registers
    always_comb begin
        // Per-input handshake terms, reused on each loop pass
        logic push;
        logic pop;
        push = 1'b0;
        pop  = 1'b0;
        // Everything holds unless a branch below moves it
        st_next = st_reg;
        // Input buffers: pop is broadcast so every reader sees the same word
        for (int i = 0; i < lane_xbar_pkg::PHY_LANES; i++) begin
            push = phyValid[i] && st_reg.inRdy[i];
            pop  = linkReady && !emptyBits[i];
            if (push) begin
                st_next.mem[i][st_reg.wp[i]] = phyData[i];
                st_next.wp[i] = !st_reg.wp[i];
            end
            if (pop) begin
                st_next.rp[i] = !st_reg.rp[i];
            end
            st_next.cnt[i]   = st_reg.cnt[i] + {1'b0, push} - {1'b0, pop};
            // Ready drops as soon as the buffer fills
            st_next.inRdy[i] = st_next.cnt[i] != lane_xbar_pkg::CNT_FULL;
        end
        // Logical lanes advance only when the receiver takes words
        if (linkReady) begin
            for (int j = 0; j < lane_xbar_pkg::LOG_LANES; j++) begin
                st_next.outData[j]  = selHead[j];
                st_next.outValid[j] = selValid[j];
            end
        end
        // Register writes, reserved bits discarded
        if (regWrEn) begin
            case (regAddr)
                lane_xbar_pkg::ROUTE45_ADDR: begin
                    st_next.route45 = regWrData[5:0];
                end
                lane_xbar_pkg::ROUTE67_ADDR: begin
                    st_next.route67 = regWrData[5:0];
                end
                default: begin
                    // Status and unmapped writes ignored
                end
            endcase
        end
        // Register reads, answer one cycle later
        st_next.rdValid = regRdEn;
        if (regRdEn) begin
            case (regAddr)
                lane_xbar_pkg::ROUTE45_ADDR: begin
                    st_next.rdData = {2'h0, st_reg.route45};
                end
                lane_xbar_pkg::ROUTE67_ADDR: begin
                    st_next.rdData = {2'h0, st_reg.route67};
                end
                lane_xbar_pkg::FULL_ADDR: begin
                    st_next.rdData = fullBits;
                end
                lane_xbar_pkg::EMPTY_ADDR: begin
                    st_next.rdData = emptyBits;
                end
                default: begin
                    st_next.rdData = 8'h00;
                end
            endcase
        end
    end

    // State register
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            st_reg          <= '0;
            st_reg.route45  <= lane_xbar_pkg::ROUTE45_RST;
            st_reg.route67  <= lane_xbar_pkg::ROUTE67_RST;
            st_reg.inRdy    <= 8'hff;
        end else begin
            st_reg <= st_next;
        end
    end

    // Outputs straight from state flops
    assign regRdData    = st_reg.rdData;
    assign regRdValid   = st_reg.rdValid;
    assign phyReady     = st_reg.inRdy;
    assign logicalData  = st_reg.outData;
    assign logicalValid = st_reg.outValid;

    // Checks
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!rstn);

    // Each lane word is the head of the input its field names, one edge on
    lane4_route_a: assert property (
        $past(linkReady) |->
        logicalData[0] == $past(headData[st_reg.route45[lane_xbar_pkg::SEL_LO_LSB +: 3]]))
        else $error("lane 4 word not from selected input");
    lane5_route_a: assert property (
        $past(linkReady) |->
        logicalData[1] == $past(headData[st_reg.route45[lane_xbar_pkg::SEL_HI_LSB +: 3]]))
        else $error("lane 5 word not from selected input");
    lane6_route_a: assert property (
        $past(linkReady) |->
        logicalData[2] == $past(headData[st_reg.route67[lane_xbar_pkg::SEL_LO_LSB +: 3]]))
        else $error("lane 6 word not from selected input");
    lane7_route_a: assert property (
        $past(linkReady) |->
        logicalData[3] == $past(headData[st_reg.route67[lane_xbar_pkg::SEL_HI_LSB +: 3]]))
        else $error("lane 7 word not from selected input");

    // Route writes land one edge later, reserved bits dropped
    route45_write_a: assert property (
        regWrEn && regAddr == lane_xbar_pkg::ROUTE45_ADDR |=>
        st_reg.route45 == $past(regWrData[5:0]))
        else $error("route four five write lost");
    route67_write_a: assert property (
        regWrEn && regAddr == lane_xbar_pkg::ROUTE67_ADDR |=>
        st_reg.route67 == $past(regWrData[5:0]))
        else $error("route six seven write lost");

    // Every read gets exactly one answer strobe, one edge later
    read_answer_a: assert property (
        regRdValid == $past(regRdEn))
        else $error("read answer strobe misplaced");

    // Status reads return the live flags of the cycle the read was taken
    full_status_a: assert property (
        regRdEn && regAddr == lane_xbar_pkg::FULL_ADDR |=>
        regRdValid && regRdData == $past(fullBits))
        else $error("full status read mismatch");
    full_ready_a: assert property (fullBits == ~phyReady)
        else $error("ready not tied to full flag");
    empty_status_a: assert property (
        regRdEn && regAddr == lane_xbar_pkg::EMPTY_ADDR |=>
        regRdValid && regRdData == $past(emptyBits))
        else $error("empty status read mismatch");

    // A buffer is never full and empty at once
    flag_clash_a: assert property (!(|(fullBits & emptyBits)))
        else $error("input buffer both full and empty");

    // Lanes 4 and 5 sharing an input carry the same word and valid
    shared_source_a: assert property (
        $past(linkReady) && $past(sel[0]) == $past(sel[1]) |->
        logicalData[0] == logicalData[1] && logicalValid[0] == logicalValid[1])
        else $error("shared input delivered unequally");

    // Stalled receiver: lane outputs hold
    stall_hold_a: assert property (!linkReady |=> $stable(logicalData) && $stable(logicalValid))
        else $error("logical lanes moved during stall");

    // Fill count never passes the two entries of a buffer
    genvar c;
    generate
        for (c = 0; c < lane_xbar_pkg::PHY_LANES; c++) begin : g_chk
            fill_bound_a: assert property (st_reg.cnt[c] <= lane_xbar_pkg::CNT_FULL)
                else $error("input buffer over filled");
        end
    endgenerate
endmodule

//--- logic/lane_xbar_pkg.sv
package lane_xbar_pkg;
    // Lane counts and widths
    localparam int PHY_LANES  = 8;
    localparam int LOG_LANES  = 4;
    localparam int DATA_W     = 8;
    localparam int SEL_W      = 3;
    localparam int ADDR_W     = 12;
    localparam int FIFO_DEPTH = 2;
    // Register byte addresses
    localparam logic [11:0] ROUTE45_ADDR = 12'h30a;
    localparam logic [11:0] ROUTE67_ADDR = 12'h30b;
    localparam logic [11:0] FULL_ADDR    = 12'h30c;
    localparam logic [11:0] EMPTY_ADDR   = 12'h30d;
    // Select field positions within a route register
    localparam int SEL_LO_LSB = 0;
    localparam int SEL_HI_LSB = 3;
    localparam int ROUTE_W    = 6;
    // Reset values
    localparam logic [5:0] ROUTE45_RST = 6'h2c;
    localparam logic [5:0] ROUTE67_RST = 6'h3e;
    localparam logic [1:0] CNT_FULL    = 2'h2;
    // Whole state of the crossbar slice
    typedef struct packed {
        logic [5:0]            route45;  // Selects for lanes 4 and 5
        logic [5:0]            route67;  // Selects for lanes 6 and 7
        logic [7:0][1:0][7:0]  mem;      // Two-entry buffer per input
        logic [7:0]            wp;       // Write pointers
        logic [7:0]            rp;       // Read pointers
        logic [7:0][1:0]       cnt;      // Fill counts
        logic [7:0]            inRdy;    // Ready towards each input
        logic [3:0][7:0]       outData;  // Logical lane words
        logic [3:0]            outValid; // Logical lane valids
        logic [7:0]            rdData;   // Read answer
        logic                  rdValid;  // Read answer strobe
    } state_t;
endpackage

//--- tb/lane_source_model.sv
`timescale 1ns/1ns
// Far-end transmitter: one word stream per serial input
module lane_source_model (
    input  wire logic            core_clk,
    input  wire logic            sendEn,
    input  wire logic [7:0]      phyReady,
    output logic      [7:0][7:0] phyData,
    output logic      [7:0]      phyValid
);
    logic [7:0][4:0] seqReg  = '0; // Words taken per input
    logic [7:0][7:0] lastReg = '0; // Last word taken
    // Word is count over index; idle lines show the inverse
    always_comb begin
        for (int n = 0; n < 8; n++) begin
            phyValid[n] = sendEn;
            phyData[n]  = sendEn ? {seqReg[n], 3'(n)} : ~lastReg[n];
        end
    end
    // A word stands until the device takes it
    always @(posedge core_clk) begin
        for (int n = 0; n < 8; n++) begin
            if (phyValid[n] && phyReady[n]) begin
                seqReg[n]  <= seqReg[n] + 5'h01;
                lastReg[n] <= phyData[n];
            end
        end
    end
endmodule

//--- tb/tb_top.sv
`timescale 1ns/1ns
// Route rounds: corners first, then random selects
module tb_top;
    logic            core_clk = 1'b0, nrst = 1'b0;   // Clock, reset
    logic            regWrEn = 1'b0, regRdEn = 1'b0; // Strobes
    logic [11:0]     regAddr = 12'h000;               // Address
    logic [7:0]      regWrData = 8'h00, regRdData;    // Data
    logic            regRdValid, linkReady = 1'b0, sendEn = 1'b0;
    logic [7:0][7:0] phyData;                         // From far end
    logic [7:0]      phyValid, phyReady;
    logic [3:0][7:0] logicalData;                     // Lanes 4..7
    logic [3:0]      logicalValid;
    logic [4:0]      seq = 5'h00;                     // Round count
    int              mismatches = 0, samples_checked = 0;
    // 100 ns period
    always #50 core_clk = ~core_clk;
    serial_lane_crossbar_upper uut (.core_clk(core_clk), .nrst(nrst),
        .regAddr(regAddr), .regWrEn(regWrEn), .regWrData(regWrData),
        .regRdEn(regRdEn), .regRdData(regRdData), .regRdValid(regRdValid),
        .phyData(phyData), .phyValid(phyValid), .phyReady(phyReady),
        .linkReady(linkReady), .logicalData(logicalData),
        .logicalValid(logicalValid));
    lane_source_model far_end (.core_clk(core_clk), .sendEn(sendEn),
        .phyReady(phyReady), .phyData(phyData), .phyValid(phyValid));
    // Compare and count
    task automatic chk(input string what, input logic [7:0] e, input logic [7:0] g);
        samples_checked++;
        if (g !== e) begin
            mismatches++;
            $display("[ERR] %s expected %h seen %h", what, e, g);
        end
    endtask
    // Word the far end sends as its q-th word on input src
    function automatic logic [7:0] word(input logic [4:0] q, input logic [2:0] src);
        return {q, src};
    endfunction
    // One-cycle write strobe
    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        @(posedge core_clk);
        {regWrEn, regAddr, regWrData} <= {1'b1, a, d};
        @(posedge core_clk);
        regWrEn <= 1'b0;
    endtask
    // One-cycle read strobe, answer one cycle later
    task automatic rd(input logic [11:0] a, input logic [7:0] e);
        @(posedge core_clk);
        {regRdEn, regAddr} <= {1'b1, a};
        @(posedge core_clk);
        regRdEn <= 1'b0;
        @(negedge core_clk);
        chk("regRdValid", 8'h01, {7'h00, regRdValid});
        chk("regRdData", e, regRdData);
    endtask
    // Program routes, check flags, take one word per lane
    task automatic round(input logic [11:0] s);
        logic [7:0] hi;
        hi = 8'($urandom) & 8'hc0;
        wr(12'h30a, hi | {2'h0, s[5:0]});
        wr(12'h30b, hi | {2'h0, s[11:6]});
        rd(12'h30a, {2'h0, s[5:0]});
        rd(12'h30b, {2'h0, s[11:6]});
        rd(12'h30c, 8'hff);
        chk("phyReady", 8'h00, phyReady);
        rd(12'h30d, 8'h00);
        @(posedge core_clk);
        linkReady <= 1'b1;
        @(posedge core_clk);
        linkReady <= 1'b0;
        @(negedge core_clk);
        for (int k = 0; k < 4; k++)
            chk("logicalData", word(seq, s[3*k +: 3]), logicalData[k]);
        chk("logicalValid", 8'h0f, {4'h0, logicalValid});
        seq++;
    endtask
    // Verdict and end of run
    task automatic close_out;
        if (mismatches == 0 && samples_checked > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    // Main sequence
    initial begin
        void'($urandom(13));
        repeat (2) @(posedge core_clk);
        nrst <= 1'b1;
        repeat (3) @(posedge core_clk);
        rd(12'h30a, 8'h2c);
        rd(12'h30b, 8'h3e);
        rd(12'h30c, 8'h00);
        chk("phyReady", 8'hff, phyReady);
        rd(12'h30d, 8'hff);
        rd(12'h300, 8'h00);
        wr(12'h30c, 8'h55);
        // Receiver takes with every input empty: no lane valid
        @(posedge core_clk);
        linkReady <= 1'b1;
        @(posedge core_clk);
        linkReady <= 1'b0;
        @(negedge core_clk);
        chk("logicalValid", 8'h00, {4'h0, logicalValid});
        sendEn <= 1'b1;
        round({3'h7, 3'h6, 3'h5, 3'h4});
        round({3'h3, 3'h3, 3'h3, 3'h3});
        round({3'h0, 3'h1, 3'h2, 3'h7});
        repeat (8) round(12'($urandom));
        close_out();
    end
    // Hang guard, well past the expected run
    initial begin
        repeat (3000) @(posedge core_clk);
        mismatches++;
        close_out();
    end
endmodule
